/* src/trg_pkg.sv */
/*
  Package for the table read guard and part identification block:
  register byte addresses, field positions, reset values, block ranges.
  Assumes a 22-bit byte address space for configuration and program memory.
*/
package trg_pkg;
  localparam int unsigned ADDR_W          = 22;
  localparam logic [21:0] ADDR_GUARD_LOW  = 22'h30000C;
  localparam logic [21:0] ADDR_GUARD_HIGH = 22'h30000D;
  localparam logic [21:0] ADDR_ID_LOW     = 22'h3FFFFE;
  localparam logic [21:0] ADDR_ID_HIGH    = 22'h3FFFFF;
  localparam int unsigned NUM_REGIONS     = 5;
  localparam int unsigned BOOT_IDX        = 4;
  localparam int unsigned POS_BLK0        = 0;
  localparam int unsigned POS_BLK1        = 1;
  localparam int unsigned POS_BLK2        = 2;
  localparam int unsigned POS_BLK3        = 3;
  localparam int unsigned POS_BOOT        = 6;
  localparam logic [7:0]  GUARD_LOW_MASK  = 8'h0F;
  localparam logic [7:0]  GUARD_HIGH_MASK = 8'h40;
  localparam logic [4:0]  GUARD_RESET     = 5'h1F;
  localparam logic [21:0] BOOT_LO         = 22'h000000;
  localparam logic [21:0] BOOT_HI         = 22'h0001FF;
  localparam logic [21:0] BLK0_LO         = 22'h000200;
  localparam logic [21:0] BLK0_HI         = 22'h001FFF;
  localparam logic [21:0] BLK1_LO         = 22'h002000;
  localparam logic [21:0] BLK1_HI         = 22'h003FFF;
  localparam logic [21:0] BLK2_LO         = 22'h004000;
  localparam logic [21:0] BLK2_HI         = 22'h005FFF;
  localparam logic [21:0] BLK3_LO         = 22'h006000;
  localparam logic [21:0] BLK3_HI         = 22'h007FFF;
  localparam int unsigned ID_LOW_POS      = 5;
  localparam logic [2:0]  PART_ID_LOW_DEF = 3'h6; // Arbitrary value
  localparam logic [7:0]  PART_ID_HIGH_DEF = 8'h5A; // Arbitrary value
  localparam logic [4:0]  REVISION_DEF    = 5'h03; // Arbitrary value
  localparam logic [7:0]  DENIED_DATA     = 8'h00;
endpackage

/* src/trg_region.sv */
/*
  One guarded program-memory region: reports whether an address falls
  inside it. Assumes inclusive bounds given as parameters.
*/
`timescale 1ns/1ns
`default_nettype none
module trg_region
#(
  parameter logic [21:0] LO = 22'h000000,
  parameter logic [21:0] HI = 22'h000000
)
(
  // Address under test
  input  wire logic [21:0] addr,
  // Hit flag
  output logic             hit
);
  assign hit = (addr >= LO) && (addr <= HI);
endmodule // trg_region
`default_nettype wire

/* src/trg_guard.sv */
/*
  Table read guard with part identification registers. Holds the five
  clear-only read guard bits, refuses table reads of a guarded region
  issued from code in another region, and answers register reads.
  Assumes a single-cycle strobed register port on the core clock and a
  table-read engine on the same clock that waits for its answer one
  cycle after the request.
*/
// The plain strobed port was chosen for this implementation.
// Summary of operation
// - Block 3 guard refuses foreign table reads
// - Block 2 guard refuses foreign table reads
// - Block 0 guard refuses foreign table reads
// - Boot guard refuses foreign table reads
// - Guards reset to one, only clearable
// - Unused guard bits read as zero
// - Part identifier split over two bytes
`timescale 1ns/1ns
`default_nettype none
module trg_guard
(
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // Register port
  input  wire logic [trg_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]                 reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [7:0]                 reg_rdata,
  // Table read request
  input  wire logic                       tbl_req,
  input  wire logic [trg_pkg::ADDR_W-1:0] tbl_addr,
  input  wire logic [trg_pkg::ADDR_W-1:0] exec_pc,
  // Program memory data and answer
  input  wire logic [7:0]                 mem_rdata,
  output logic                            tbl_ack,
  output logic      [7:0]                 tbl_data,
  output logic                            tbl_denied,
  // Guard state seen by other logic
  output logic      [4:0]                 guard_bits
);
  import trg_pkg::*;

  logic [4:0] guard_reg;
  logic [4:0] guard_next;
  logic [4:0] tgt_hit;
  logic [4:0] src_hit;
  logic       deny;
  logic [7:0] rd_next;
  logic [7:0] id_low;
  logic [7:0] guard_low_view;
  logic [7:0] guard_high_view;

  // Region decoders, index 0..3 blocks, 4 boot
  trg_region #(.LO(BLK0_LO), .HI(BLK0_HI)) u_t0 (.addr(tbl_addr), .hit(tgt_hit[0]));
  trg_region #(.LO(BLK1_LO), .HI(BLK1_HI)) u_t1 (.addr(tbl_addr), .hit(tgt_hit[1]));
  trg_region #(.LO(BLK2_LO), .HI(BLK2_HI)) u_t2 (.addr(tbl_addr), .hit(tgt_hit[2]));
  trg_region #(.LO(BLK3_LO), .HI(BLK3_HI)) u_t3 (.addr(tbl_addr), .hit(tgt_hit[3]));
  trg_region #(.LO(BOOT_LO), .HI(BOOT_HI)) u_tb (.addr(tbl_addr), .hit(tgt_hit[4]));
  trg_region #(.LO(BLK0_LO), .HI(BLK0_HI)) u_s0 (.addr(exec_pc), .hit(src_hit[0]));
  trg_region #(.LO(BLK1_LO), .HI(BLK1_HI)) u_s1 (.addr(exec_pc), .hit(src_hit[1]));
  trg_region #(.LO(BLK2_LO), .HI(BLK2_HI)) u_s2 (.addr(exec_pc), .hit(src_hit[2]));
  trg_region #(.LO(BLK3_LO), .HI(BLK3_HI)) u_s3 (.addr(exec_pc), .hit(src_hit[3]));
  trg_region #(.LO(BOOT_LO), .HI(BOOT_HI)) u_sb (.addr(exec_pc), .hit(src_hit[4]));

  // Guard bits: writing zero clears, writing one leaves unchanged
  always_comb
  begin
    guard_next = guard_reg;
    if (reg_wr && reg_addr == ADDR_GUARD_LOW)
    begin
      guard_next[0] = guard_reg[0] & reg_wdata[POS_BLK0];
      guard_next[1] = guard_reg[1] & reg_wdata[POS_BLK1];
      guard_next[2] = guard_reg[2] & reg_wdata[POS_BLK2];
      guard_next[3] = guard_reg[3] & reg_wdata[POS_BLK3];
    end
    if (reg_wr && reg_addr == ADDR_GUARD_HIGH)
    begin
      guard_next[BOOT_IDX] = guard_reg[BOOT_IDX] & reg_wdata[POS_BOOT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      guard_reg <= GUARD_RESET;
    else
      guard_reg <= guard_next;
  end

  // A guarded region refuses reads unless code runs in that same region
  assign deny = |(tgt_hit & ~guard_reg & ~src_hit);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tbl_ack    <= 1'b0;
      tbl_data   <= DENIED_DATA;
      tbl_denied <= 1'b0;
    end
    else
    begin
      tbl_ack    <= tbl_req;
      tbl_denied <= tbl_req & deny;
      if (tbl_req)
        tbl_data <= deny ? DENIED_DATA : mem_rdata;
    end
  end

  // Register views with unused bits forced to zero
  assign guard_low_view  = {4'h0, guard_reg[3:0]} & GUARD_LOW_MASK;
  assign guard_high_view = {1'b0, guard_reg[BOOT_IDX], 6'h00} & GUARD_HIGH_MASK;
  assign id_low          = {PART_ID_LOW_DEF, REVISION_DEF};

  always_comb
  begin
    rd_next = 8'h00;
    case (reg_addr)
      ADDR_GUARD_LOW:  rd_next = guard_low_view;
      ADDR_GUARD_HIGH: rd_next = guard_high_view;
      ADDR_ID_LOW:     rd_next = id_low;
      ADDR_ID_HIGH:    rd_next = PART_ID_HIGH_DEF;
      default:         rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_next;
    else
      reg_rdata <= 8'h00;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      guard_bits <= GUARD_RESET;
    else
      guard_bits <= guard_next;
  end

  AST_GUARD_NEVER_SETS: assert property (
    @(posedge clk) disable iff (!rst_n)
    ##1 !$past(guard_reg[0]) |-> !guard_reg[0])
    else $error("guard bit returned to one");

  AST_BOOT_NEVER_SETS: assert property (
    @(posedge clk) disable iff (!rst_n)
    ##1 !$past(guard_reg[BOOT_IDX]) |-> !guard_reg[BOOT_IDX])
    else $error("boot guard returned to one");

  AST_BLK3_DENY: assert property (
    @(posedge clk) disable iff (!rst_n)
    tbl_req && !guard_reg[3] && tgt_hit[3] && !src_hit[3] |=> tbl_denied && tbl_data == DENIED_DATA)
    else $error("block 3 foreign read passed");

  AST_BLK2_DENY: assert property (
    @(posedge clk) disable iff (!rst_n)
    tbl_req && !guard_reg[2] && tgt_hit[2] && !src_hit[2] |=> tbl_denied)
    else $error("block 2 foreign read passed");

  AST_BLK1_DENY: assert property (
    @(posedge clk) disable iff (!rst_n)
    tbl_req && !guard_reg[1] && tgt_hit[1] && !src_hit[1] |=> tbl_denied)
    else $error("block 1 foreign read passed");

  AST_BLK0_DENY: assert property (
    @(posedge clk) disable iff (!rst_n)
    tbl_req && !guard_reg[0] && tgt_hit[0] && !src_hit[0] |=> tbl_denied)
    else $error("block 0 foreign read passed");

  AST_BOOT_DENY: assert property (
    @(posedge clk) disable iff (!rst_n)
    tbl_req && !guard_reg[4] && tgt_hit[4] && !src_hit[4] |=> tbl_denied)
    else $error("boot foreign read passed");

  AST_OPEN_PASSES: assert property (
    @(posedge clk) disable iff (!rst_n)
    tbl_req && (tgt_hit & ~guard_reg) == 5'h00 |=> tbl_ack && !tbl_denied
      && tbl_data == $past(mem_rdata))
    else $error("unguarded read refused or corrupted");

  AST_UNUSED_ZERO: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == ADDR_GUARD_LOW |=> reg_rdata[7:4] == 4'h0)
    else $error("unused block guard bit read nonzero");

  AST_ID_HIGH: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == ADDR_ID_HIGH |=> reg_rdata == PART_ID_HIGH_DEF)
    else $error("id high byte wrong");

  AST_ID_LOW: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == ADDR_ID_LOW |=> reg_rdata[4:0] == REVISION_DEF
      && reg_rdata[7:5] == PART_ID_LOW_DEF)
    else $error("id low byte wrong");

  AST_GUARD_NO_RISE: assert property (
    @(posedge clk) disable iff (!rst_n)
    ##1 (guard_reg & ~$past(guard_reg)) == 5'h00)
    else $error("a guard bit returned to one");

  AST_GUARD_HOLD: assert property (
    @(posedge clk) disable iff (!rst_n)
    !(reg_wr && (reg_addr == ADDR_GUARD_LOW || reg_addr == ADDR_GUARD_HIGH))
      |=> $stable(guard_reg))
    else $error("guard bits changed without a guard write");

  AST_CLEAR_LOW: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == ADDR_GUARD_LOW
      |=> guard_reg[3:0] == ($past(guard_reg[3:0]) & $past(reg_wdata[3:0])))
    else $error("block guard write not applied as clear only");

  AST_CLEAR_BOOT: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == ADDR_GUARD_HIGH
      |=> guard_reg[BOOT_IDX] == ($past(guard_reg[BOOT_IDX]) & $past(reg_wdata[POS_BOOT])))
    else $error("boot guard write not applied as clear only");

  AST_GUARD_MIRROR: assert property (
    @(posedge clk) disable iff (!rst_n)
    guard_bits == guard_reg)
    else $error("guard output differs from guard state");

  AST_RESET_STATE: assert property (
    @(posedge clk)
    !rst_n |=> guard_reg == GUARD_RESET && guard_bits == GUARD_RESET
      && !tbl_ack && !tbl_denied && reg_rdata == 8'h00)
    else $error("state after reset wrong");

  AST_LOW_VIEW: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == ADDR_GUARD_LOW |=> reg_rdata == {4'h0, $past(guard_reg[3:0])})
    else $error("block guards read back wrong");

  AST_HIGH_VIEW: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == ADDR_GUARD_HIGH
      |=> reg_rdata == {1'b0, $past(guard_reg[BOOT_IDX]), 6'h00})
    else $error("boot guard read back wrong");

  AST_UNUSED_ZERO_HIGH: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == ADDR_GUARD_HIGH
      |=> reg_rdata[7] == 1'b0 && reg_rdata[5:0] == 6'h00)
    else $error("unused boot guard bit read nonzero");

  AST_UNMAPPED_ZERO: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr != ADDR_GUARD_LOW && reg_addr != ADDR_GUARD_HIGH
      && reg_addr != ADDR_ID_LOW && reg_addr != ADDR_ID_HIGH |=> reg_rdata == 8'h00)
    else $error("unmapped register read nonzero");

  AST_RDATA_IDLE: assert property (
    @(posedge clk) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data shown without a read");

  AST_ACK_FOLLOWS: assert property (
    @(posedge clk) disable iff (!rst_n)
    tbl_req |=> tbl_ack)
    else $error("table read not answered");

  AST_ACK_DROPS: assert property (
    @(posedge clk) disable iff (!rst_n)
    !tbl_req |=> !tbl_ack && !tbl_denied)
    else $error("table answer without a request");

  AST_DENY_DATA_ZERO: assert property (
    @(posedge clk) disable iff (!rst_n)
    tbl_denied |-> tbl_ack && tbl_data == DENIED_DATA)
    else $error("refused read leaked data");

  AST_DATA_HOLDS: assert property (
    @(posedge clk) disable iff (!rst_n)
    !tbl_req |=> $stable(tbl_data))
    else $error("table data changed without a request");

  AST_SAME_REGION_PASSES: assert property (
    @(posedge clk) disable iff (!rst_n)
    tbl_req && (tgt_hit & src_hit) != 5'h00 |=> !tbl_denied)
    else $error("read from own region refused");

  AST_ABOVE_BLOCKS_OPEN: assert property (
    @(posedge clk) disable iff (!rst_n)
    tbl_req && tbl_addr > BLK3_HI |=> !tbl_denied)
    else $error("unguarded address refused");

  AST_TARGET_ONE_REGION: assert property (
    @(posedge clk) disable iff (!rst_n)
    $onehot0(tgt_hit))
    else $error("target address in two regions");

  AST_SOURCE_ONE_REGION: assert property (
    @(posedge clk) disable iff (!rst_n)
    $onehot0(src_hit))
    else $error("executing address in two regions");
endmodule // trg_guard
`default_nettype wire

/* dv/trg_guard_bench.sv */
/*
  Self-checking bench for the table read guard: register reads and writes,
  guarded and unguarded table reads. Assumes trg_pkg and trg_guard from src/.
*/
`timescale 1ns/1ns
`default_nettype none
module trg_guard_bench;
  import trg_pkg::*;
  logic        clk        = 1'b0;
  logic        rst_n      = 1'b0;
  logic        reg_wr     = 1'b0;
  logic        reg_rd     = 1'b0;
  logic        tbl_req    = 1'b0;
  logic [21:0] reg_addr   = 22'h000000;
  logic [21:0] tbl_addr   = 22'h000000;
  logic [21:0] exec_pc    = 22'h000000;
  logic [7:0]  reg_wdata  = 8'h00;
  logic [7:0]  mem_rdata  = 8'h00;
  logic [7:0]  reg_rdata;
  logic [7:0]  tbl_data;
  logic        tbl_ack;
  logic        tbl_denied;
  logic [4:0]  guard_bits;
  logic [4:0]  gexp;
  logic [21:0] lo [5];
  logic [21:0] hi [5];
  int          errors     = 0;
  int          compares   = 0;

  always #10 clk = ~clk;

  trg_guard dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
                 .tbl_req, .tbl_addr, .exec_pc, .mem_rdata, .tbl_ack, .tbl_data,
                 .tbl_denied, .guard_bits);

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out;
    if (errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [21:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // Read strobe, data checked in the following cycle
  task automatic rd(input logic [21:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk("reg_rdata", e, reg_rdata);
  endtask

  // Table read with answer one cycle after the request
  task automatic tr(input logic [21:0] a, input logic [21:0] p, input logic dn);
    @(posedge clk);
    tbl_req   <= 1'b1;
    tbl_addr  <= a;
    exec_pc   <= p;
    mem_rdata <= a[7:0] ^ 8'hA5;
    @(posedge clk);
    tbl_req   <= 1'b0;
    mem_rdata <= 8'h00;
    #1;
    chk("tbl_ack", 8'h01, {7'h00, tbl_ack});
    chk("tbl_denied", {7'h00, dn}, {7'h00, tbl_denied});
    chk("tbl_data", dn ? DENIED_DATA : (a[7:0] ^ 8'hA5), tbl_data);
    @(posedge clk);
    #1;
    chk("tbl_ack_drop", 8'h00, {6'h00, tbl_ack, tbl_denied});
    chk("tbl_data_hold", dn ? DENIED_DATA : (a[7:0] ^ 8'hA5), tbl_data);
  endtask

  initial
  begin
    lo   = '{BLK0_LO, BLK1_LO, BLK2_LO, BLK3_LO, BOOT_LO};
    hi   = '{BLK0_HI, BLK1_HI, BLK2_HI, BLK3_HI, BOOT_HI};
    gexp = 5'h1F;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("guard_bits", {3'h0, GUARD_RESET}, {3'h0, guard_bits});
    rd(ADDR_GUARD_LOW, 8'h0F);
    rd(ADDR_GUARD_HIGH, 8'h40);
    rd(ADDR_ID_LOW, {PART_ID_LOW_DEF, REVISION_DEF});
    rd(ADDR_ID_HIGH, PART_ID_HIGH_DEF);
    rd(22'h30000E, 8'h00);
    wr(ADDR_ID_LOW, 8'h00);
    wr(ADDR_ID_HIGH, 8'h00);
    rd(ADDR_ID_LOW, {PART_ID_LOW_DEF, REVISION_DEF});
    rd(ADDR_ID_HIGH, PART_ID_HIGH_DEF);
    tr(BLK3_LO, BOOT_LO, 1'b0);
    for (int i = 0; i < 5; i++)
    begin
      if (i < 4)
        wr(ADDR_GUARD_LOW, 8'(~(8'h01 << i)));
      else
        wr(ADDR_GUARD_HIGH, 8'hBF);
      gexp[i] = 1'b0;
      wr(ADDR_GUARD_LOW, 8'hFF);
      wr(ADDR_GUARD_HIGH, 8'hFF);
      rd(ADDR_GUARD_LOW, {4'h0, gexp[3:0]});
      rd(ADDR_GUARD_HIGH, {1'b0, gexp[4], 6'h00});
      chk("guard_bits", {3'h0, gexp}, {3'h0, guard_bits});
      tr(hi[i], lo[(i + 1) % 5], 1'b1);
      tr(lo[i], lo[i] - 22'h000001, 1'b1);
      tr(lo[i], hi[i], 1'b0);
    end
    tr(22'h008000, BOOT_LO, 1'b0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("guard_bits", {3'h0, GUARD_RESET}, {3'h0, guard_bits});
    rd(ADDR_GUARD_LOW, 8'h0F);
    rd(ADDR_GUARD_HIGH, 8'h40);
    close_out();
  end
endmodule // trg_guard_bench
`default_nettype wire
